// >>> hw/swc_pkg.sv
// package for the sleep/wake-up controller
// assumes apb slave access with 32-bit data, one register per word
package swc_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] SWC_OFF_GIC    = 12'h000;
  localparam logic [11:0] SWC_OFF_PERIPHERAL_IRQ_ENABLE_ONE   = 12'h004;
  localparam logic [11:0] SWC_OFF_PERIPHERAL_IRQ_ENABLE_TWO   = 12'h008;
  localparam logic [11:0] SWC_OFF_PERIPHERAL_IRQ_FLAGS_ONE   = 12'h00C;
  localparam logic [11:0] SWC_OFF_PERIPHERAL_IRQ_FLAGS_TWO   = 12'h010;
  localparam logic [11:0] SWC_OFF_STATUS = 12'h014;
  localparam logic [11:0] SWC_OFF_WDTCFG = 12'h018;
  localparam logic [11:0] SWC_OFF_WDCNT  = 12'h01C;

  // ==========================================================
  // field positions
  localparam int SWC_GIC_GIE   = 7;
  localparam int SWC_GIC_PERIPHERAL_GROUP_ENABLE  = 6;
  localparam int SWC_STAT_TO   = 4;
  localparam int SWC_STAT_PD   = 3;
  localparam int SWC_STAT_SLP  = 0;
  localparam int SWC_WCFG_EN   = 0;
  localparam int SWC_WCFG_SLP  = 1;

  // implemented bit masks
  localparam logic [7:0] SWC_MASK_GIC  = 8'hFF;
  localparam logic [7:0] SWC_MASK_PERIPHERAL_IRQ_ENABLE_ONE = 8'hF1;
  localparam logic [7:0] SWC_MASK_PERIPHERAL_IRQ_ENABLE_TWO = 8'h04;
  localparam logic [7:0] SWC_MASK_PERIPHERAL_IRQ_FLAGS_ONE = 8'hF1;
  localparam logic [7:0] SWC_MASK_PERIPHERAL_IRQ_FLAGS_TWO = 8'h04;
  localparam logic [7:0] SWC_MASK_WCFG = 8'h03;

  // reset values
  localparam logic [7:0]  SWC_RST_REG  = 8'h00;
  localparam logic [1:0]  SWC_RST_STAT = 2'b11;
  localparam logic [31:0] SWC_RST_ZERO = 32'h0000_0000;

  // ==========================================================
  // timing and vectors
  localparam int          SWC_LFOSC_HZ  = 31000;
  localparam int          SWC_PCLK_HZ   = 50000000;
  localparam int          SWC_LF_DIV    = SWC_PCLK_HZ / SWC_LFOSC_HZ;
  localparam logic [10:0] SWC_LF_DIV_M1 = 11'(SWC_LF_DIV - 1);
  localparam logic [15:0] SWC_WDT_LIMIT = 16'h07D0;
  localparam logic [12:0] SWC_ISR_VEC   = 13'h0004;
  localparam logic [1:0]  SWC_DUMMY_CYC = 2'd2;

  // ==========================================================
  // types
  typedef enum logic [2:0]
  {
    SWC_RUN   = 3'b000,
    SWC_HALT  = 3'b001,
    SWC_SLEEP = 3'b010,
    SWC_PREF  = 3'b011,
    SWC_DUMMY = 3'b100
  } swc_state_e;

  typedef struct packed
  {
    logic [12:0] pc;
    logic        vector;
    logic        clk_en;
  } swc_core_s;

endpackage

// >>> hw/swc_top.sv
// sleep/wake-up controller with interrupt flag registers and apb slave
// assumes core halt/ifetch strobes synchronous to pclk; reset via presetn
//
// Operation
// - flags set on their condition regardless of enables
// - second flag register holds display flag at bit 2, others zero
// - sleep entered only by the halt instruction
// - watchdog cleared on sleep entry, keeps counting if enabled and also allowed in sleep
// - sleep entry clears powerdown flag and sets timeout flag
// - cpu clock gated in sleep; slow oscillators keep running
// - converter on its rc clock and sensing oscillator keep running
// - io ports hold their state through sleep
// - sleep leaves non-watchdog resets unchanged
// - resets give full reset; watchdog or interrupts resume execution
// - halt prefetches the instruction at pc plus one
// - interrupt wakes only if its enable set, whatever global enable
// - global enable clear resumes in line; set vectors to 0004h
// - watchdog cleared on every wake-up
// - pending enabled interrupt before halt makes halt idle_op while global enable clear
// - interrupt during halt completes sleep then wakes at once
// - peripheral interrupts need the peripheral group enable
// - watchdog timeout in sleep wakes instead of resetting
`timescale 1ns/1ps

module swc_top
  import swc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        halt_exec,
  input  wire logic        instr_done,
  input  wire logic        clrwdt,
  input  wire logic [12:0] core_pc,
  input  wire logic [2:0]  core_irq_set,
  input  wire logic [7:0]  peripheral_irq_flags_one_set,
  input  wire logic        display_irq_set,
  input  wire logic [7:0]  port_out_in,
  input  wire logic [7:0]  port_oe_in,
  output logic             cpu_clk_en,
  output logic             low_freq_internal_osc_en,
  output logic             secondary_osc_en,
  output logic             converter_rc_clock_en,
  output logic             sense_osc_en,
  output logic             fetch_req,
  output logic [12:0]      fetch_pc,
  output logic             vector_take,
  output logic             dummy_cycle,
  output logic             halt_skipped,
  output logic [7:0]       port_out,
  output logic [7:0]       port_oe,
  output logic             sleeping
);

  typedef struct packed
  {
    swc_state_e  fsm;
    logic [7:0]  gic;
    logic [7:0]  peripheral_irq_enable_one;
    logic [7:0]  peripheral_irq_enable_two;
    logic [7:0]  peripheral_irq_flags_one;
    logic [7:0]  peripheral_irq_flags_two;
    logic        pd;
    logic        to;
    logic [7:0]  wcfg;
    logic        vec_pend;
    logic [1:0]  dcnt;
    logic        wdt_clr;
    logic        clk_en;
    logic        fetch;
    logic [12:0] fpc;
    logic        vtake;
    logic        dummy;
    logic        skipped;
    logic [7:0]  pout;
    logic [7:0]  poe;
    logic        rdy;
    logic [31:0] rdata;
    logic        err;
  } swc_top_s;

  swc_top_s st_reg;
  swc_top_s st_next;

  logic [15:0] wdt_count;
  logic        wdt_timeout;
  logic        wdt_run;
  logic        wake_req;
  logic        apb_wr;
  logic        apb_rd;
  logic        presetn_q;
  logic        sleep_q;

  // ========================================================
  // helpers
  function automatic logic [7:0] swc_masked(input logic [7:0] v,
                                            input logic [7:0] m);
    swc_masked = v & m;
  endfunction

  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] off);
    addr_hit = (a == off);
  endfunction

  // ========================================================
  // wake request
  always_comb
  begin
    wake_req = |(st_reg.gic[5:3] & st_reg.gic[2:0]);
    if (st_reg.gic[SWC_GIC_PERIPHERAL_GROUP_ENABLE])
      wake_req = wake_req
               | (|(st_reg.peripheral_irq_enable_one & st_reg.peripheral_irq_flags_one))
               | (|(st_reg.peripheral_irq_enable_two & st_reg.peripheral_irq_flags_two));
  end

  // watchdog runs awake when enabled, asleep only if also allowed
  assign wdt_run = st_reg.wcfg[SWC_WCFG_EN]
                 & ((st_reg.fsm != SWC_SLEEP)
                    | st_reg.wcfg[SWC_WCFG_SLP]);

  swc_wdt u_wdt
  (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (st_reg.wdt_clr),
    .run     (wdt_run),
    .count   (wdt_count),
    .timeout (wdt_timeout)
  );

  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~penable & ~pwrite;

  // ========================================================
  // next state
  always_comb
  begin
    st_next         = st_reg;
    st_next.wdt_clr = clrwdt;
    st_next.fetch   = 1'b0;
    st_next.vtake   = 1'b0;
    st_next.dummy   = 1'b0;
    st_next.rdy     = psel & ~penable;
    st_next.err     = 1'b0;

    // apb register writes
    if (apb_wr)
    begin
      if (addr_hit(paddr, SWC_OFF_GIC))
        st_next.gic = swc_masked(pwdata[7:0], SWC_MASK_GIC);
      else if (addr_hit(paddr, SWC_OFF_PERIPHERAL_IRQ_ENABLE_ONE))
        st_next.peripheral_irq_enable_one = swc_masked(pwdata[7:0], SWC_MASK_PERIPHERAL_IRQ_ENABLE_ONE);
      else if (addr_hit(paddr, SWC_OFF_PERIPHERAL_IRQ_ENABLE_TWO))
        st_next.peripheral_irq_enable_two = swc_masked(pwdata[7:0], SWC_MASK_PERIPHERAL_IRQ_ENABLE_TWO);
      else if (addr_hit(paddr, SWC_OFF_PERIPHERAL_IRQ_FLAGS_ONE))
        st_next.peripheral_irq_flags_one = swc_masked(pwdata[7:0], SWC_MASK_PERIPHERAL_IRQ_FLAGS_ONE);
      else if (addr_hit(paddr, SWC_OFF_PERIPHERAL_IRQ_FLAGS_TWO))
        st_next.peripheral_irq_flags_two = swc_masked(pwdata[7:0], SWC_MASK_PERIPHERAL_IRQ_FLAGS_TWO);
      else if (addr_hit(paddr, SWC_OFF_WDTCFG))
        st_next.wcfg = swc_masked(pwdata[7:0], SWC_MASK_WCFG);
    end

    // flag sets win over software clears
    st_next.gic[2:0] = st_next.gic[2:0] | core_irq_set;
    st_next.peripheral_irq_flags_one = st_next.peripheral_irq_flags_one
                 | swc_masked(peripheral_irq_flags_one_set, SWC_MASK_PERIPHERAL_IRQ_FLAGS_ONE);
    st_next.peripheral_irq_flags_two[2] = st_next.peripheral_irq_flags_two[2] | display_irq_set;

    // apb read data, sampled in setup for a fixed zero-wait answer
    if (apb_rd)
    begin
      st_next.rdata = SWC_RST_ZERO;
      if (addr_hit(paddr, SWC_OFF_GIC))
        st_next.rdata[7:0] = st_reg.gic;
      else if (addr_hit(paddr, SWC_OFF_PERIPHERAL_IRQ_ENABLE_ONE))
        st_next.rdata[7:0] = st_reg.peripheral_irq_enable_one;
      else if (addr_hit(paddr, SWC_OFF_PERIPHERAL_IRQ_ENABLE_TWO))
        st_next.rdata[7:0] = st_reg.peripheral_irq_enable_two;
      else if (addr_hit(paddr, SWC_OFF_PERIPHERAL_IRQ_FLAGS_ONE))
        st_next.rdata[7:0] = st_reg.peripheral_irq_flags_one;
      else if (addr_hit(paddr, SWC_OFF_PERIPHERAL_IRQ_FLAGS_TWO))
        st_next.rdata[7:0] = st_reg.peripheral_irq_flags_two;
      else if (addr_hit(paddr, SWC_OFF_STATUS))
      begin
        st_next.rdata[SWC_STAT_TO]  = st_reg.to;
        st_next.rdata[SWC_STAT_PD]  = st_reg.pd;
        st_next.rdata[SWC_STAT_SLP] = (st_reg.fsm == SWC_SLEEP);
      end
      else if (addr_hit(paddr, SWC_OFF_WDTCFG))
        st_next.rdata[7:0] = st_reg.wcfg;
      else if (addr_hit(paddr, SWC_OFF_WDCNT))
        st_next.rdata[15:0] = wdt_count;
    end
    if (psel & ~penable & (paddr > SWC_OFF_WDCNT || paddr[1:0] != 2'b00))
      st_next.err = 1'b1;

    // awake: watchdog timeout resets via the system, not modelled here
    if (st_reg.fsm != SWC_SLEEP && wdt_timeout)
      st_next.to = 1'b0;

    case (st_reg.fsm)
      SWC_RUN:
      begin
        st_next.clk_en = 1'b1;
        if (halt_exec)
        begin
          st_next.fetch = 1'b1;
          st_next.fpc   = core_pc + 13'd1;
          if (!st_reg.gic[SWC_GIC_GIE] && wake_req)
            st_next.skipped = 1'b1;
          else
          begin
            st_next.skipped = 1'b0;
            st_next.pout    = port_out_in;
            st_next.poe     = port_oe_in;
            st_next.wdt_clr = 1'b1;
            st_next.pd      = 1'b0;
            st_next.to      = 1'b1;
            st_next.fsm     = SWC_HALT;
          end
        end
        else
        begin
          st_next.pout = port_out_in;
          st_next.poe  = port_oe_in;
        end
      end
      SWC_HALT:
      begin
        st_next.clk_en = 1'b0;
        st_next.fsm    = SWC_SLEEP;
      end
      SWC_SLEEP:
      begin
        st_next.clk_en = 1'b0;
        if (wake_req || wdt_timeout)
        begin
          if (wdt_timeout)
          begin
            st_next.to = 1'b0;
            st_next.pd = 1'b0;
          end
          st_next.wdt_clr  = 1'b1;
          st_next.vec_pend = st_reg.gic[SWC_GIC_GIE] & wake_req;
          st_next.clk_en   = 1'b1;
          st_next.fsm      = SWC_PREF;
        end
      end
      SWC_PREF:
      begin
        st_next.clk_en = 1'b1;
        if (instr_done) // prefetched instruction retires
        begin
          if (st_reg.vec_pend)
          begin
            st_next.dcnt  = SWC_DUMMY_CYC;
            st_next.fsm   = SWC_DUMMY;
            st_next.dummy = 1'b1;
          end
          else
            st_next.fsm = SWC_RUN;
        end
      end
      SWC_DUMMY:
      begin
        if (st_reg.dcnt == 2'd1)
        begin
          st_next.vtake    = 1'b1;
          st_next.fetch    = 1'b1;
          st_next.fpc      = SWC_ISR_VEC;
          st_next.vec_pend = 1'b0;
          st_next.fsm      = SWC_RUN;
        end
        else
          st_next.dummy = 1'b1;
        st_next.dcnt = st_reg.dcnt - 2'd1;
      end
      default:
        st_next.fsm = SWC_RUN;
    endcase
  end

  // ========================================================
  // state register; presetn is the por/bor/reset-pin path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg        <= '0;
      st_reg.fsm    <= SWC_RUN;
      st_reg.to     <= SWC_RST_STAT[1];
      st_reg.pd     <= SWC_RST_STAT[0];
      st_reg.clk_en <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ========================================================
  // outputs
  assign cpu_clk_en               = st_reg.clk_en;
  assign low_freq_internal_osc_en = presetn_q;
  assign secondary_osc_en         = presetn_q;
  assign converter_rc_clock_en    = presetn_q;
  assign sense_osc_en             = presetn_q;
  assign fetch_req                = st_reg.fetch;
  assign fetch_pc                 = st_reg.fpc;
  assign vector_take              = st_reg.vtake;
  assign dummy_cycle              = st_reg.dummy;
  assign halt_skipped             = st_reg.skipped;
  assign port_out                 = st_reg.pout;
  assign port_oe                  = st_reg.poe;
  assign sleeping                 = sleep_q;
  assign pready                   = st_reg.rdy;
  assign prdata                   = st_reg.rdata;
  assign pslverr                  = st_reg.err;

  // oscillator enables and sleep level from their own flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presetn_q <= 1'b0;
      sleep_q   <= 1'b0;
    end
    else
    begin
      presetn_q <= 1'b1;
      sleep_q   <= (st_next.fsm == SWC_SLEEP);
    end
  end

endmodule

// >>> hw/swc_wdt.sv
// watchdog counter clocked by a 31 kHz enable pulse
// assumes pclk at 50 MHz; the divider makes the slow rate
`timescale 1ns/1ps

module swc_wdt
  import swc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clear,
  input  wire logic        run,
  output logic [15:0]      count,
  output logic             timeout
);

  typedef struct packed
  {
    logic [10:0] div;
    logic [15:0] cnt;
    logic        tmo;
  } swc_wdt_s;

  swc_wdt_s st_reg;
  swc_wdt_s st_next;

  // ========================================================
  // counter
  always_comb
  begin
    st_next     = st_reg;
    st_next.tmo = 1'b0;
    if (st_reg.div == SWC_LF_DIV_M1)
      st_next.div = 11'd0;
    else
      st_next.div = st_reg.div + 11'd1;
    if (clear)
    begin
      st_next.cnt = 16'h0000;
      st_next.div = 11'd0;
    end
    else if (run && st_reg.div == SWC_LF_DIV_M1)
    begin
      if (st_reg.cnt == SWC_WDT_LIMIT)
      begin
        st_next.cnt = 16'h0000;
        st_next.tmo = 1'b1;
      end
      else
        st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign count   = st_reg.cnt;
  assign timeout = st_reg.tmo;

endmodule

// >>> testbench/swc_core_model.sv
// core model: issues halts, retires the prefetched op after wake
// assumes pclk domain and the controller's cpu_clk_en
`timescale 1ns/1ps

module swc_core_model #(
  parameter int RETIRE_DLY = 1
)
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  cpu_clk_en,
  output logic       halt_exec,
  output logic       instr_done,
  output logic [12:0] core_pc,
  output logic [7:0] port_out_in,
  output logic [7:0] port_oe_in
);
  logic clk_en_q;
  int   left;

  initial
  begin
    halt_exec = 1'b0;
    instr_done = 1'b0;
    core_pc = 13'h0000;
    port_out_in = 8'h5A;
    port_oe_in = 8'h0F;
    clk_en_q = 1'b1;
    left = 0;
  end

  // ==========================================================
  // live ports change every cycle; retire after clock returns
  always @(posedge pclk)
  begin
    port_out_in <= port_out_in + 8'h01;
    port_oe_in <= ~port_oe_in;
    clk_en_q <= cpu_clk_en;
    instr_done <= (left == 1);
    if (presetn && cpu_clk_en && !clk_en_q)
      left <= RETIRE_DLY;
    else if (left > 0)
      left <= left - 1;
  end

  // one halt instruction at the given address
  task automatic do_halt(input logic [12:0] pc);
    @(posedge pclk);
    halt_exec <= 1'b1;
    core_pc <= pc;
    @(posedge pclk);
    halt_exec <= 1'b0;
  endtask
endmodule

// >>> testbench/swc_top_asserts.sv
// checker for the sleep/wake-up controller ports
// assumes one pclk domain; bound onto swc_top below
`timescale 1ns/1ps

module swc_top_asserts
  import swc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        halt_exec,
  input wire logic [12:0] core_pc,
  input wire logic        cpu_clk_en,
  input wire logic        low_freq_internal_osc_en,
  input wire logic        secondary_osc_en,
  input wire logic        converter_rc_clock_en,
  input wire logic        sense_osc_en,
  input wire logic        fetch_req,
  input wire logic [12:0] fetch_pc,
  input wire logic        vector_take,
  input wire logic        dummy_cycle,
  input wire logic        halt_skipped,
  input wire logic [7:0]  port_out,
  input wire logic        sleeping
);
  // ==========================================================
  // sequences
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_dummy2;
    dummy_cycle [*2];
  endsequence

  sequence s_vector;
    vector_take && fetch_req && (fetch_pc == SWC_ISR_VEC);
  endsequence

  // ==========================================================
  // properties
  a_sleep_by_halt: assert property (
    $rose(sleeping) |-> $past(halt_exec, 1) || $past(halt_exec, 2)
      || $past(halt_exec, 3)) else $error("sleep without halt");
  a_clk_gated: assert property (
    sleeping |-> !cpu_clk_en) else $error("cpu clock runs in sleep");
  a_slow_osc_on: assert property (
    sleeping |-> low_freq_internal_osc_en && secondary_osc_en)
    else $error("slow oscillator stopped in sleep");
  a_conv_osc_on: assert property (
    sleeping |-> converter_rc_clock_en && sense_osc_en)
    else $error("converter clock stopped in sleep");
  a_ports_frozen: assert property (
    sleeping && $past(sleeping) |-> $stable(port_out))
    else $error("port changed in sleep");
  a_halt_prefetch: assert property (
    halt_exec && !sleeping |=> fetch_req
      && fetch_pc == $past(core_pc) + 13'h0001)
    else $error("no prefetch of next address");
  a_vector_dummy: assert property (
    $rose(dummy_cycle) |-> s_dummy2 ##1 s_vector)
    else $error("vector not after two dummy cycles");
  a_skip_awake: assert property (
    $rose(halt_skipped) |-> (cpu_clk_en && !sleeping) [*3])
    else $error("skipped halt still slept");
  a_flags_zero: assert property (
    pready && !pwrite && paddr == SWC_OFF_PERIPHERAL_IRQ_FLAGS_TWO
      |-> prdata[31:3] == 29'h0 && prdata[1:0] == 2'h0)
    else $error("unused flag bits not zero");
endmodule

bind swc_top swc_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .halt_exec(halt_exec), .core_pc(core_pc), .cpu_clk_en(cpu_clk_en),
  .low_freq_internal_osc_en(low_freq_internal_osc_en),
  .secondary_osc_en(secondary_osc_en),
  .converter_rc_clock_en(converter_rc_clock_en),
  .sense_osc_en(sense_osc_en), .fetch_req(fetch_req),
  .fetch_pc(fetch_pc), .vector_take(vector_take),
  .dummy_cycle(dummy_cycle), .halt_skipped(halt_skipped),
  .port_out(port_out), .sleeping(sleeping));

// >>> testbench/tb.sv
// testbench: apb register tests and sleep/wake sequences
// assumes swc_top, the core model and the bound checker
`timescale 1ns/1ps

module tb;
  import swc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic        halt_exec, instr_done, display_irq_set, err_flag;
  logic [12:0] core_pc, fetch_pc;
  logic [7:0]  peripheral_irq_flags_one_set, port_out_in, port_oe_in;
  logic        cpu_clk_en, fetch_req, vector_take, halt_skipped, sleeping;
  int          err_total, num_checks, n;
  logic        clrwdt, lf_osc_en, dummy_cycle;
  logic [2:0]  core_irq;
  logic [7:0]  port_out, p_hold;
  int          n_dummy;

  swc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .halt_exec(halt_exec), .instr_done(instr_done), .clrwdt(clrwdt),
    .core_pc(core_pc), .core_irq_set(core_irq), .peripheral_irq_flags_one_set(peripheral_irq_flags_one_set),
    .display_irq_set(display_irq_set), .port_out_in(port_out_in),
    .port_oe_in(port_oe_in), .cpu_clk_en(cpu_clk_en),
    .low_freq_internal_osc_en(lf_osc_en), .secondary_osc_en(),
    .converter_rc_clock_en(), .sense_osc_en(), .fetch_req(fetch_req),
    .fetch_pc(fetch_pc), .vector_take(vector_take),
    .dummy_cycle(dummy_cycle), .halt_skipped(halt_skipped),
    .port_out(port_out), .port_oe(), .sleeping(sleeping));

  swc_core_model #(.RETIRE_DLY(3)) u_core (.pclk(pclk),
    .presetn(presetn), .cpu_clk_en(cpu_clk_en), .halt_exec(halt_exec),
    .instr_done(instr_done), .core_pc(core_pc),
    .port_out_in(port_out_in), .port_oe_in(port_oe_in));

  always #10 pclk = ~pclk;

  // dummy cycles seen before the vector
  always @(posedge pclk)
    if (dummy_cycle === 1'b1)
      n_dummy++;

  // ==========================================================
  // tasks
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd_data = prdata;
    err_flag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      err_total++;
      results();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_data, exp);
  endtask

  task automatic wait_sig(input int sel, input logic v);
    int k;
    for (k = 0; k < 60; k++)
    begin
      @(posedge pclk);
      #1;
      if ((sel == 0 ? sleeping : sel == 1 ? vector_take : halt_skipped)
          === v)
        break;
    end
    if (k == 60)
    begin
      err_total++;
      results();
    end
  endtask

  task automatic irq(input logic [7:0] p1);
    @(posedge pclk);
    display_irq_set <= 1'b1;
    peripheral_irq_flags_one_set <= p1;
    @(posedge pclk);
    display_irq_set <= 1'b0;
    peripheral_irq_flags_one_set <= 8'h00;
  endtask

  // ==========================================================
  // sequence
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h0000_0000;
    display_irq_set = 0; peripheral_irq_flags_one_set = 8'h00; err_total = 0; num_checks = 0;
    clrwdt = 0; core_irq = 3'b000; n_dummy = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(SWC_OFF_PERIPHERAL_IRQ_FLAGS_TWO, 32'h0000_0000);
    chk({31'h0, lf_osc_en}, 32'h0000_0001);
    rd(SWC_OFF_STATUS, 32'h0000_0018);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk({31'h0, err_flag}, 32'h0000_0001);
    irq(8'hFF);
    rd(SWC_OFF_PERIPHERAL_IRQ_FLAGS_ONE, 32'h0000_00F1);
    rd(SWC_OFF_PERIPHERAL_IRQ_FLAGS_TWO, 32'h0000_0004);
    apb(1'b1, SWC_OFF_PERIPHERAL_IRQ_FLAGS_ONE, 32'h0000_0000);
    apb(1'b1, SWC_OFF_PERIPHERAL_IRQ_FLAGS_TWO, 32'h0000_0000);
    rd(SWC_OFF_PERIPHERAL_IRQ_FLAGS_TWO, 32'h0000_0000);
    // enabled flag pending before the halt
    apb(1'b1, SWC_OFF_PERIPHERAL_IRQ_ENABLE_TWO, 32'h0000_0004);
    apb(1'b1, SWC_OFF_GIC, 32'h0000_0040);
    irq(8'h00);
    u_core.do_halt(13'h0100);
    wait_sig(2, 1'b1);
    chk({31'h0, sleeping}, 32'h0000_0000);
    rd(SWC_OFF_STATUS, 32'h0000_0018);
    apb(1'b1, SWC_OFF_PERIPHERAL_IRQ_FLAGS_TWO, 32'h0000_0000);
    // sleep, wake by interrupt with global enable clear
    u_core.do_halt(13'h0200);
    wait_sig(0, 1'b1);
    rd(SWC_OFF_STATUS, 32'h0000_0011);
    chk({31'h0, cpu_clk_en}, 32'h0000_0000);
    irq(8'h00);
    wait_sig(0, 1'b0);
    rd(SWC_OFF_STATUS, 32'h0000_0010);
    n = 0;
    repeat (12)
    begin
      @(posedge pclk);
      #1;
      n += int'(vector_take === 1'b1);
    end
    chk(32'(n), 32'h0000_0000);
    chk({31'h0, halt_skipped}, 32'h0000_0000);
    // group enable off, then on while asleep with global enable
    apb(1'b1, SWC_OFF_PERIPHERAL_IRQ_FLAGS_TWO, 32'h0000_0000);
    apb(1'b1, SWC_OFF_GIC, 32'h0000_0000);
    u_core.do_halt(13'h0300);
    wait_sig(0, 1'b1);
    irq(8'h00);
    repeat (10) @(posedge pclk);
    #1;
    chk({31'h0, sleeping}, 32'h0000_0001);
    apb(1'b1, SWC_OFF_GIC, 32'h0000_00C0);
    wait_sig(0, 1'b0);
    wait_sig(1, 1'b1);
    chk({19'h0, fetch_pc}, 32'h0000_0004);
    chk(32'(n_dummy), 32'h0000_0002);
    // core source wakes without group enable; watchdog cleared
    apb(1'b1, SWC_OFF_GIC, 32'h0000_0008);
    apb(1'b1, SWC_OFF_WDTCFG, 32'h0000_0001);
    @(posedge pclk);
    clrwdt <= 1'b1;
    @(posedge pclk);
    clrwdt <= 1'b0;
    repeat (1700) @(posedge pclk);
    rd(SWC_OFF_WDCNT, 32'h0000_0001);
    u_core.do_halt(13'h0400);
    wait_sig(0, 1'b1);
    p_hold = port_out;
    repeat (5) @(posedge pclk);
    chk({24'h0, port_out}, {24'h0, p_hold});
    @(posedge pclk);
    core_irq <= 3'b001;
    @(posedge pclk);
    core_irq <= 3'b000;
    wait_sig(0, 1'b0);
    rd(SWC_OFF_GIC, 32'h0000_0009);
    rd(SWC_OFF_WDCNT, 32'h0000_0000);
    results();
  end
endmodule
